// ---- rtl/hlc_link_regs.vh ----
// register map, field positions and fixed patterns of the link controller
`ifndef HLC_LINK_REGS_VH
`define HLC_LINK_REGS_VH
// -------------------------------------------------------------------------
// register offsets
// -------------------------------------------------------------------------
`define HLC_A_ADDR1    5'h10
`define HLC_A_ADDR2    5'h11
`define HLC_A_CTL1     5'h13
`define HLC_A_STAT     5'h14
`define HLC_A_CTL2     5'h15
`define HLC_A_FIFO     5'h16
`define HLC_A_BCNT     5'h17
`define HLC_A_FCS1     5'h18
`define HLC_A_FCS2     5'h19
`define HLC_A_SRST     5'h1b
// -------------------------------------------------------------------------
// control one, control two and soft reset fields
// -------------------------------------------------------------------------
`define HLC_C1_FILL    2
`define HLC_C1_FA      3
`define HLC_C1_EOP     4
`define HLC_C1_TX_ENABLE_BIT    5
`define HLC_C1_RX_ENABLE_BIT    6
`define HLC_C1_ADREC   7
`define HLC_C2_CYCLE   0
`define HLC_C2_FCSINH  1
`define HLC_C2_SEVEN   2
`define HLC_C2_LPTR    3
`define HLC_C2_LPRT    4
`define HLC_SR_BIT     0
// -------------------------------------------------------------------------
// patterns and counts
// -------------------------------------------------------------------------
`define HLC_FLAG       8'h7e
`define HLC_ABORT      8'h7f
`define HLC_GOAHEAD    8'hfe
`define HLC_ONES       8'hff
`define HLC_CRC_INIT   16'hffff
`define HLC_CRC_GOOD   16'hf0b8
`define HLC_CRC_POLY   16'h8408
`define HLC_IDLE_RUN   4'hf
`define HLC_STUFF_RUN  3'h5
`define HLC_SKIP_BITS  4'h8
`define HLC_HOLD_BITS  16'h0018
`define HLC_MIN_BITS   16'h0019
`define HLC_ABT_BITS   16'h001a
`define HLC_GOOD_BITS  16'h0020
`define HLC_FIFO_DEPTH 8'h80
`define HLC_ST_IDLE    2'h0
`define HLC_ST_DATA    2'h1
`define HLC_ST_FCS     2'h2
`define HLC_ST_CLOSE   2'h3
`endif

// ---- rtl/hlc_link.v ----
// bit-oriented packet link controller with tagged transmit and receive fifos
//
// How it works
// [R1] fifteen or more ones means idle channel
// [R2] detect go-ahead zero, seven ones, zero
// [R3] pin or soft reset clears control registers
// [R4] two loopbacks; independent transmit and receive
// [R5] receive bytes stored with two-bit tag
// [R6] transmit ones idle, or flags when fill set
// [R7] wait for data; opening flag from ones
// [R8] tag bits stored with byte, then cleared
// [R9] byte countdown tags end of packet, reloads
// [R10] send bytes, fcs, one shared closing flag
// [R11] abort tag sends 7f, then idle
// [R12] empty fifo mid-packet flags underrun, aborts
// [R13] transmit enable immediate; disable after packet
// [R14] fcs inhibit sends flags and data only
// [R15] under 25 bits dropped; 25-31 bad
// [R16] flag sync; good only if residue f0b8
// [R17] last 16 bits withheld as fcs
// [R18] first byte, and second byte unless seven-bit mode, matched against address registers
// [R19] end written pulse and end at output
// [R20] overflow stops writing until next flag
// [R21] receive disable waits for stored packet
// [R22] received fcs kept as sent, inverted
// [R23] ccitt crc, complement sent lsb first
// [R24] zero inserted after five ones, removed
// [R25] frames delimited by 7e flags
// [R26] seven ones after 26 bits aborts packet
`timescale 1ns/1ns
`include "hlc_link_regs.vh"
module hlc_link (
   input  wire       clk_sys_i,
   input  wire       resetn_i,
   input  wire [4:0] cpu_addr_i,
   input  wire [7:0] cpu_wdata_i,
   input  wire       cpu_wr_i,
   input  wire       cpu_rd_i,
   input  wire       rx_data_i,
   input  wire       rx_bit_clk_i,
   input  wire       tx_bit_clk_i,
   output reg  [7:0] cpu_rdata_o,
   output reg        tx_data_o,
   output reg        rx_end_written_o,
   output reg        rx_end_at_output_o
);
// -------------------------------------------------------------------------
// functions
// -------------------------------------------------------------------------
function [15:0] crc_step;
   input [15:0] c;
   input        b;
   begin
      crc_step = (c[0] ^ b) ? ((c >> 1) ^ `HLC_CRC_POLY) : (c >> 1);
   end
endfunction
function [15:0] rev16;
   input [15:0] v;
   integer      i;
   begin
      for (i = 0; i < 16; i = i + 1) begin
         rev16[i] = v[15 - i];
      end
   end
endfunction
function addr_ok;
   input [7:0] b;
   input [7:0] r;
   input       sev;
   begin
      addr_ok = !r[0] || (sev ? (r[7:1] == b[6:0]) : (r[7:1] == b[7:1]));
   end
endfunction
// -------------------------------------------------------------------------
// reset release, pin synchronisers and soft reset
// -------------------------------------------------------------------------
reg        rst_s1_reg, rst_n_reg;
reg  [2:0] rxc_reg, txc_reg;
reg  [1:0] rxd_reg;
reg        srst_reg;
always @(posedge clk_sys_i or negedge resetn_i) begin
   if (!resetn_i) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
   end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
   end
end
always @(posedge clk_sys_i or negedge rst_n_reg) begin
   if (!rst_n_reg) begin
      rxc_reg <= 3'h0;
      txc_reg <= 3'h0;
      rxd_reg <= 2'h0;
   end else begin
      rxc_reg <= {rxc_reg[1:0], rx_bit_clk_i};
      txc_reg <= {txc_reg[1:0], tx_bit_clk_i};
      rxd_reg <= {rxd_reg[0], rx_data_i};
   end
end
// the edge detectors look only at the second and third stages
wire       rx_pin_tick = rxc_reg[1] & ~rxc_reg[2];
wire       tx_tick     = txc_reg[1] & ~txc_reg[2];
wire       cpu_wr_fifo = cpu_wr_i && cpu_addr_i == `HLC_A_FIFO;
wire       cpu_rd_fifo = cpu_rd_i && cpu_addr_i == `HLC_A_FIFO;
// -------------------------------------------------------------------------
// state declarations
// -------------------------------------------------------------------------
reg  [7:0] addr1_reg, addr2_reg, ctl1_reg, ctl2_reg, bcnt_reg, bload_reg;
reg [15:0] rx_fcs_reg;
reg        ovf_reg, ga_reg, und_reg;
reg  [9:0] txf [0:127];
reg  [6:0] txw_reg, txr_reg;
reg  [7:0] txn_reg;
reg  [9:0] rxf [0:127];
reg  [6:0] rxw_reg, rxr_reg;
reg  [7:0] rxn_reg;
reg        rwe_reg;
reg  [9:0] rwd_reg;
reg  [1:0] tst_reg;
reg [15:0] tsh_reg, tcrc_reg;
reg  [4:0] tlen_reg;
reg  [1:0] tkind_reg;
reg  [2:0] tones_reg;
reg        tlast_flag_reg;
reg  [7:0] h_reg;
reg  [3:0] rones_reg, skip_reg;
reg  [2:0] oones_reg;
reg        in_frame_reg, wrote_reg, pend_v_reg, ev_close_reg, ev_abort_reg;
reg  [7:0] pend_reg;
reg [23:0] d24_reg;
reg [15:0] rbits_reg, rcrc_reg;
wire       tx_en   = ctl1_reg[`HLC_C1_TX_ENABLE_BIT];
wire       tx_run  = tx_en | (tst_reg != `HLC_ST_IDLE);                  // [R13]
wire       rx_run  = ctl1_reg[`HLC_C1_RX_ENABLE_BIT] | (in_frame_reg & wrote_reg); // [R21]
wire [9:0] rx_head = rxf[rxr_reg];
wire       rx_nemp = rxn_reg != 8'h00;
// -------------------------------------------------------------------------
// transmitter: choice of the next unit to send
// -------------------------------------------------------------------------
reg [15:0] nx_sh;
reg  [4:0] nx_len;
reg  [1:0] nx_kind, nx_st;
reg        nx_pop, nx_und, nx_flag, take, tbit, stuff;
reg  [9:0] te;
always @* begin
   te      = txf[txr_reg];
   nx_sh   = {8'h00, ctl1_reg[`HLC_C1_FILL] ? `HLC_FLAG : `HLC_ONES}; // [R6]
   nx_len  = 5'h08;
   nx_kind = 2'h0;
   nx_st   = `HLC_ST_IDLE;
   nx_pop  = 1'b0;
   nx_und  = 1'b0;
   nx_flag = ctl1_reg[`HLC_C1_FILL];
   take    = 1'b0;
   case (tst_reg)
      `HLC_ST_IDLE: begin
         if (txn_reg != 8'h00 && tx_en) begin                         // [R7]
            if (tlast_flag_reg) begin
               take = 1'b1;
            end else begin
               nx_sh   = {8'h00, `HLC_FLAG};                          // [R25]
               nx_st   = `HLC_ST_DATA;
               nx_flag = 1'b1;
            end
         end
      end
      `HLC_ST_DATA: begin
         take = 1'b1;
      end
      `HLC_ST_FCS: begin
         nx_sh   = ~tcrc_reg;                                         // [R23]
         nx_len  = 5'h10;
         nx_kind = 2'h1;
         nx_st   = `HLC_ST_CLOSE;
      end
      default: begin
         nx_sh   = {8'h00, `HLC_FLAG};                                // [R10]
         nx_flag = 1'b1;
      end
   endcase
   if (take) begin
      nx_flag = 1'b0;
      if (txn_reg == 8'h00) begin
         nx_sh  = {8'h00, `HLC_ABORT};                                // [R12]
         nx_und = 1'b1;
      end else begin
         nx_pop = 1'b1;
         if (te[9]) begin
            nx_sh = {8'h00, `HLC_ABORT};                              // [R11]
         end else begin
            nx_sh   = {8'h00, te[7:0]};
            nx_kind = 2'h2;
            if (!te[8]) begin
               nx_st = `HLC_ST_DATA;
            end else if (ctl2_reg[`HLC_C2_FCSINH]) begin
               nx_st = `HLC_ST_CLOSE;                                 // [R14]
            end else begin
               nx_st = `HLC_ST_FCS;                                   // [R10]
            end
         end
      end
   end
   stuff = tkind_reg != 2'h0 && tones_reg == `HLC_STUFF_RUN;          // [R24]
   tbit  = stuff ? 1'b0 : (tlen_reg == 5'h00 ? nx_sh[0] : tsh_reg[0]);
end
wire       tbit_eff = tx_run ? tbit : 1'b1;
wire       lp_tr    = ctl2_reg[`HLC_C2_LPTR];
wire       rtick    = lp_tr ? tx_tick : rx_pin_tick;                  // [R4]
wire       rbit     = lp_tr ? tbit_eff : rxd_reg[1];
wire [7:0] hn       = {h_reg[6:0], rbit};
wire       ex       = h_reg[7];
wire [15:0] nb      = rbits_reg + 16'h0001;
wire [23:0] nd      = {ex, d24_reg[23:1]};
wire       good     = rcrc_reg == `HLC_CRC_GOOD && rbits_reg >= `HLC_GOOD_BITS; // [R16] [R17]
// -------------------------------------------------------------------------
// fifo storage
// -------------------------------------------------------------------------
always @(posedge clk_sys_i) begin
   if (cpu_wr_fifo && txn_reg != `HLC_FIFO_DEPTH) begin
      txf[txw_reg] <= {ctl1_reg[`HLC_C1_FA],                          // [R8]
                       ctl1_reg[`HLC_C1_EOP] | (bcnt_reg == 8'h01), cpu_wdata_i}; // [R9]
   end
   if (rwe_reg) begin
      rxf[rxw_reg] <= rwd_reg;                                        // [R5]
   end
end
// -------------------------------------------------------------------------
// registers, transmitter and receiver
// -------------------------------------------------------------------------
always @(posedge clk_sys_i or negedge rst_n_reg) begin
   if (!rst_n_reg) begin
      {addr1_reg, addr2_reg, ctl1_reg, ctl2_reg, bcnt_reg, bload_reg} <= 48'h0;
      {rx_fcs_reg, ovf_reg, ga_reg, und_reg, srst_reg} <= 20'h0;
      {txw_reg, txr_reg, txn_reg, rxw_reg, rxr_reg, rxn_reg} <= 44'h0;
      {rwe_reg, rwd_reg, tst_reg, tsh_reg, tcrc_reg} <= 45'h0;
      {tlen_reg, tkind_reg, tones_reg, tlast_flag_reg} <= 11'h0;
      {h_reg, rones_reg, skip_reg, oones_reg} <= 19'h0;
      {in_frame_reg, wrote_reg, pend_v_reg, ev_close_reg, ev_abort_reg} <= 5'h0;
      {pend_reg, d24_reg, rbits_reg, rcrc_reg} <= 64'h0;
      {cpu_rdata_o, rx_end_written_o, rx_end_at_output_o} <= 10'h0;
      tx_data_o <= 1'b1;
   end else if (srst_reg) begin
      // soft reset clears the controls, every pointer and the engine states, but not the transmit shift, receive data shift, bit count, crc and fcs registers
      {addr1_reg, addr2_reg, ctl1_reg, ctl2_reg, bcnt_reg, bload_reg} <= 48'h0; // [R3]
      {ovf_reg, ga_reg, und_reg, srst_reg} <= 4'h0;
      {txw_reg, txr_reg, txn_reg, rxw_reg, rxr_reg, rxn_reg} <= 44'h0;
      {rwe_reg, tst_reg, tlen_reg, tkind_reg, tones_reg, tlast_flag_reg} <= 14'h0;
      {in_frame_reg, wrote_reg, pend_v_reg, ev_close_reg, ev_abort_reg} <= 5'h0;
      {skip_reg, rones_reg, oones_reg, h_reg} <= 19'h0;
      {rx_end_written_o, rx_end_at_output_o} <= 2'h0;
      tx_data_o <= 1'b1;
   end else begin
      rwe_reg          <= 1'b0;
      rx_end_written_o <= 1'b0;
      // ---- register writes
      if (cpu_wr_i) begin
         if (cpu_addr_i == `HLC_A_ADDR1) begin
            addr1_reg <= cpu_wdata_i;
         end else if (cpu_addr_i == `HLC_A_ADDR2) begin
            addr2_reg <= cpu_wdata_i;
         end else if (cpu_addr_i == `HLC_A_CTL1) begin
            ctl1_reg <= cpu_wdata_i;                                  // [R13]
         end else if (cpu_addr_i == `HLC_A_CTL2) begin
            ctl2_reg <= cpu_wdata_i;
         end else if (cpu_addr_i == `HLC_A_BCNT) begin
            bcnt_reg  <= cpu_wdata_i;
            bload_reg <= cpu_wdata_i;
         end else if (cpu_addr_i == `HLC_A_SRST) begin
            srst_reg <= cpu_wdata_i[`HLC_SR_BIT];                     // [R3]
         end
      end
      if (cpu_wr_fifo && txn_reg != `HLC_FIFO_DEPTH) begin
         txw_reg <= txw_reg + 7'h01;
         ctl1_reg[`HLC_C1_EOP] <= 1'b0;                               // [R8]
         ctl1_reg[`HLC_C1_FA]  <= 1'b0;
         if (bcnt_reg == 8'h01 && ctl2_reg[`HLC_C2_CYCLE]) begin
            bcnt_reg <= bload_reg;                                    // [R9]
         end else if (bcnt_reg != 8'h00) begin
            bcnt_reg <= bcnt_reg - 8'h01;
         end
      end
      // ---- register reads; a read of the data port pops the receive side
      if (cpu_rd_i) begin
         if (cpu_addr_i == `HLC_A_ADDR1) begin
            cpu_rdata_o <= addr1_reg;
         end else if (cpu_addr_i == `HLC_A_ADDR2) begin
            cpu_rdata_o <= addr2_reg;
         end else if (cpu_addr_i == `HLC_A_CTL1) begin
            cpu_rdata_o <= ctl1_reg;
         end else if (cpu_addr_i == `HLC_A_STAT) begin
            cpu_rdata_o <= {rx_nemp ? rx_head[9:8] : 2'h0, ~rx_nemp, ovf_reg, // [R5]
                            ga_reg, rones_reg == `HLC_IDLE_RUN, und_reg, txn_reg == 8'h00};
         end else if (cpu_addr_i == `HLC_A_CTL2) begin
            cpu_rdata_o <= ctl2_reg;
         end else if (cpu_addr_i == `HLC_A_FIFO) begin
            cpu_rdata_o <= rx_nemp ? rx_head[7:0] : 8'h00;
         end else if (cpu_addr_i == `HLC_A_BCNT) begin
            cpu_rdata_o <= bcnt_reg;
         end else if (cpu_addr_i == `HLC_A_FCS1) begin
            cpu_rdata_o <= rx_fcs_reg[15:8];                          // [R22]
         end else if (cpu_addr_i == `HLC_A_FCS2) begin
            cpu_rdata_o <= rx_fcs_reg[7:0];
         end else begin
            cpu_rdata_o <= 8'h00;
         end
      end
      // sticky status clears on a status read unless set again this cycle
      if (cpu_rd_i && cpu_addr_i == `HLC_A_STAT) begin
         {ovf_reg, ga_reg, und_reg} <= 3'h0;
      end
      if (cpu_rd_fifo && rx_nemp) begin
         rxr_reg <= rxr_reg + 7'h01;
      end
      rxn_reg <= rxn_reg + {7'h00, rwe_reg} - {7'h00, cpu_rd_fifo && rx_nemp};
      if (rwe_reg) begin
         rxw_reg <= rxw_reg + 7'h01;
      end
      rx_end_at_output_o <= rx_nemp && rx_head[9];                    // [R19]
      // ---- transmitter, one bit per transmit tick
      txn_reg <= txn_reg + {7'h00, cpu_wr_fifo && txn_reg != `HLC_FIFO_DEPTH}
                 - {7'h00, tx_tick && tx_run && !stuff && tlen_reg == 5'h00 && nx_pop};
      if (tx_tick) begin
         tx_data_o <= ctl2_reg[`HLC_C2_LPRT] ? rxd_reg[1] : tbit_eff; // [R4]
      end
      if (tx_tick && tx_run) begin
         if (stuff) begin
            tones_reg <= 3'h0;                                        // [R24]
         end else begin
            if (tlen_reg == 5'h00) begin
               tsh_reg        <= nx_sh >> 1;
               tlen_reg       <= nx_len - 5'h01;
               tkind_reg      <= nx_kind;
               tst_reg        <= nx_st;
               tlast_flag_reg <= nx_flag;
               if (nx_pop) begin
                  txr_reg <= txr_reg + 7'h01;
               end
               if (nx_und) begin
                  und_reg <= 1'b1;                                    // [R12]
               end
               tcrc_reg  <= (nx_kind == 2'h0) ? `HLC_CRC_INIT :
                            (nx_kind == 2'h2) ? crc_step(tcrc_reg, tbit) : tcrc_reg;
               // a run of ones carries on across a unit boundary inside the frame
               tones_reg <= (nx_kind == 2'h0 || !tbit) ? 3'h0 : (tkind_reg == 2'h0 ? 3'h1 : tones_reg + 3'h1); // [R24]
            end else begin
               tsh_reg   <= tsh_reg >> 1;
               tlen_reg  <= tlen_reg - 5'h01;
               tcrc_reg  <= (tkind_reg == 2'h2) ? crc_step(tcrc_reg, tbit) : tcrc_reg; // [R23]
               tones_reg <= tbit ? tones_reg + 3'h1 : 3'h0;
            end
         end
      end
      // ---- receiver, one raw bit per receive tick
      if (rtick && rx_run) begin
         h_reg     <= hn;
         rones_reg <= !rbit ? 4'h0 : (rones_reg == `HLC_IDLE_RUN ? rones_reg : rones_reg + 4'h1); // [R1]
         if (ex == 1'b0 && hn == `HLC_GOAHEAD) begin
            ga_reg <= 1'b1;                                           // [R2]
         end
         if (hn == `HLC_FLAG) begin
            ev_close_reg <= 1'b1;                                     // [R25]
            skip_reg     <= `HLC_SKIP_BITS;
         end else if (hn == `HLC_ABORT && in_frame_reg) begin
            ev_abort_reg <= 1'b1;                                     // [R26]
            skip_reg     <= `HLC_SKIP_BITS;
         end else if (skip_reg != 4'h0) begin
            skip_reg <= skip_reg - 4'h1;
         end
         if (skip_reg != 4'h0) begin
            oones_reg <= 3'h0;
         end else begin
            oones_reg <= !ex ? 3'h0 : (oones_reg == 3'h7 ? oones_reg : oones_reg + 3'h1);
            if (in_frame_reg && !(ex == 1'b0 && oones_reg == `HLC_STUFF_RUN)) begin // [R24]
               rcrc_reg  <= crc_step(rcrc_reg, ex);                   // [R16]
               d24_reg   <= nd;
               rbits_reg <= nb;
               if (nb[2:0] == 3'h0 && nb >= `HLC_HOLD_BITS) begin     // [R17]
                  if (ctl1_reg[`HLC_C1_ADREC] &&
                      ((nb == `HLC_HOLD_BITS && !addr_ok(nd[7:0], addr1_reg, ctl2_reg[`HLC_C2_SEVEN])) ||
                       (nb == `HLC_GOOD_BITS && !ctl2_reg[`HLC_C2_SEVEN] &&
                        !addr_ok(nd[7:0], addr2_reg, 1'b0)))) begin  // [R18]
                     in_frame_reg <= 1'b0;
                     pend_v_reg   <= 1'b0;
                  end else begin
                     pend_reg   <= nd[7:0];
                     pend_v_reg <= 1'b1;
                     if (pend_v_reg) begin
                        if (rxn_reg == `HLC_FIFO_DEPTH) begin
                           ovf_reg      <= 1'b1;                      // [R20]
                           in_frame_reg <= 1'b0;
                        end else begin
                           rwe_reg   <= 1'b1;
                           rwd_reg   <= {2'h0, pend_reg};             // [R5]
                           wrote_reg <= 1'b1;
                        end
                     end
                  end
               end
            end
         end
      end else if (ev_close_reg || ev_abort_reg) begin
         ev_close_reg <= 1'b0;
         ev_abort_reg <= 1'b0;
         if (in_frame_reg && pend_v_reg &&
             rbits_reg >= (ev_abort_reg ? `HLC_ABT_BITS : `HLC_MIN_BITS)) begin // [R15] [R26]
            if (rxn_reg == `HLC_FIFO_DEPTH) begin
               ovf_reg <= 1'b1;                                       // [R20]
            end else begin
               rwe_reg          <= 1'b1;
               rwd_reg          <= {1'b1, ev_abort_reg | ~good, pend_reg}; // [R5] [R16]
               rx_end_written_o <= 1'b1;                              // [R19]
            end
         end
         if (in_frame_reg && ev_close_reg) begin
            rx_fcs_reg <= rev16(d24_reg[23:8]);                       // [R22]
         end
         // a new frame only starts on a flag and only while enabled
         in_frame_reg <= ev_close_reg & ctl1_reg[`HLC_C1_RX_ENABLE_BIT];       // [R21]
         wrote_reg    <= 1'b0;
         pend_v_reg   <= 1'b0;
         rbits_reg    <= 16'h0000;
         rcrc_reg     <= `HLC_CRC_INIT;
      end
   end
end
endmodule

// ---- dv/hlc_far_end.sv ----
// far-end serial source and sink for the link controller
`timescale 1ns/1ns
module hlc_far_end (
   input  wire  tx_data_i,
   output logic bit_clk_o,
   output logic rx_data_o
);
   bit q[$];
   // ----------------------------------------
   // free-running bit clock, ten system clocks per bit
   // ----------------------------------------
   initial bit_clk_o = 1'b0;
   initial rx_data_o = 1'b1;
   always #100 bit_clk_o = ~bit_clk_o;
   // queued bits win; otherwise echo the transmitter so tx frames come back
   always @(negedge bit_clk_o) rx_data_o <= (q.size() > 0) ? q.pop_front() : tx_data_i;
endmodule

// ---- dv/hlc_link_chk.sv ----
// port checks on the link controller
`timescale 1ns/1ns
module hlc_link_chk (
   input wire       clk_sys_i,
   input wire       resetn_i,
   input wire [4:0] cpu_addr_i,
   input wire [7:0] cpu_wdata_i,
   input wire       cpu_wr_i,
   input wire       cpu_rd_i,
   input wire       rx_data_i,
   input wire       rx_bit_clk_i,
   input wire       tx_bit_clk_i,
   input wire [7:0] cpu_rdata_o,
   input wire       tx_data_o,
   input wire       rx_end_written_o,
   input wire       rx_end_at_output_o
);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   AST_RD_HOLD: assert property (!$past(cpu_rd_i) |-> $stable(cpu_rdata_o))
      else $error("read data moved without a read");
   AST_SRST_RD0: assert property (cpu_rd_i && cpu_addr_i == 5'h1b |=> cpu_rdata_o == 8'h00)
      else $error("soft reset register did not read zero");
   AST_UNMAPPED: assert property (cpu_rd_i && cpu_addr_i == 5'h00 |=> cpu_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   AST_ADDR_RB: assert property (cpu_wr_i && cpu_addr_i == 5'h10 ##1 cpu_rd_i && !cpu_wr_i
      && cpu_addr_i == 5'h10 |=> cpu_rdata_o == $past(cpu_wdata_i, 2)) else $error("address register readback wrong");
   AST_TAG_CLR: assert property (cpu_wr_i && cpu_addr_i == 5'h16 ##1 cpu_rd_i && !cpu_wr_i
      && cpu_addr_i == 5'h13 |=> (cpu_rdata_o & 8'h18) == 8'h00) else $error("tag bits not cleared");
   AST_RX_END_WRITTEN_IRQ_PULSE: assert property (rx_end_written_o |=> !rx_end_written_o [*8])
      else $error("end written not a lone pulse");
   AST_TX_BIT: assert property ($changed(tx_data_o) |=> $stable(tx_data_o) [*3])
      else $error("serial output changed within a bit");
   AST_RX_END_AT_OUTPUT_IRQ_HOLD: assert property (rx_end_at_output_o && !cpu_rd_i && !cpu_wr_i && !$past(cpu_rd_i)
      && !$past(cpu_wr_i) |=> rx_end_at_output_o) else $error("end at output dropped without a read");
   cover property (rx_end_written_o);
   cover property ($rose(rx_end_at_output_o));
   cover property (cpu_wr_i && cpu_addr_i == 5'h16);
endmodule
bind hlc_link hlc_link_chk u_hlc_link_chk (.clk_sys_i, .resetn_i, .cpu_addr_i, .cpu_wdata_i, .cpu_wr_i,
   .cpu_rd_i, .rx_data_i, .rx_bit_clk_i, .tx_bit_clk_i, .cpu_rdata_o, .tx_data_o, .rx_end_written_o,
   .rx_end_at_output_o);

// ---- dv/testbench.sv ----
// self-checking bench for the link controller
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
   logic       clk_sys_i = 1'b0, resetn_i = 1'b0, cpu_wr_i = 1'b0, cpu_rd_i = 1'b0;
   logic [4:0] cpu_addr_i = 5'h00;
   logic [7:0] cpu_wdata_i = 8'h00;
   wire  [7:0] cpu_rdata_o;
   wire        tx_data_o, rx_data_i, bit_clk, rx_end_written_o, rx_end_at_output_o;
   int         n_mismatch = 0, samples_checked = 0, n_rx_end_written_irq = 0, ones = 0, k;
   logic [15:0] fr;
   always #10 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (rx_end_written_o === 1'b1) n_rx_end_written_irq++;
   hlc_far_end u_hlc_far_end (.tx_data_i(tx_data_o), .bit_clk_o(bit_clk), .rx_data_o(rx_data_i));
   hlc_link u_hlc_link (.clk_sys_i, .resetn_i, .cpu_addr_i, .cpu_wdata_i, .cpu_wr_i, .cpu_rd_i,
      .rx_data_i, .rx_bit_clk_i(bit_clk), .tx_bit_clk_i(bit_clk), .cpu_rdata_o, .tx_data_o,
      .rx_end_written_o, .rx_end_at_output_o);
   // ----------------------------------------
   // bus and serial tasks
   // ----------------------------------------
   task summarize;
      if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // waits first so a write never re-raises its own strobe in one step
   task wr(input [4:0] a, input [7:0] d);
      @(negedge clk_sys_i);
      cpu_addr_i = a;
      cpu_wdata_i = d;
      cpu_wr_i = 1'b1;
      @(negedge clk_sys_i);
      cpu_wr_i = 1'b0;
   endtask
   task rd(input [4:0] a, input [7:0] m, input [7:0] e);
      cpu_addr_i = a;
      cpu_rd_i = 1'b1;
      @(negedge clk_sys_i);
      cpu_rd_i = 1'b0;
      @(negedge clk_sys_i);
      `CHK(cpu_rdata_o & m, e)
   endtask
   task pb(input bit b, input bit s);
      u_hlc_far_end.q.push_back(b);
      ones = (s && b) ? ones + 1 : 0;
      if (ones == 5) begin
         u_hlc_far_end.q.push_back(1'b0);
         ones = 0;
      end
   endtask
   task pbyte(input [7:0] d, input bit s);
      for (int i = 0; i < 8; i++) pb(d[i], s);
   endtask
   function [15:0] crc(input [15:0] c, input [7:0] d);
      for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      return c;
   endfunction
   task wait_rx_end_written_irq(input int n);
      for (int i = 0; i < 3000 && n_rx_end_written_irq < n; i++) @(negedge clk_sys_i);
      if (n_rx_end_written_irq < n) begin
         n_mismatch++;
         summarize();
      end
   endtask
   // flip lets a scenario corrupt the check bits on purpose
   task frame(input [7:0] b0, input [7:0] b1, input [15:0] flip);
      logic [15:0] f;
      f = ~crc(crc(16'hffff, b0), b1) ^ flip;
      fr = {<<{f}};
      pbyte(8'h7e, 1'b0);
      pbyte(b0, 1'b1);
      pbyte(b1, 1'b1);
      pbyte(f[7:0], 1'b1);
      pbyte(f[15:8], 1'b1);
      pbyte(8'h7e, 1'b0);
      wait_rx_end_written_irq(n_rx_end_written_irq + 1);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (2) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      rd(5'h13, 8'hff, 8'h00);
      rd(5'h15, 8'hff, 8'h00);
      rd(5'h1b, 8'hff, 8'h00);
      rd(5'h00, 8'hff, 8'h00);
      wr(5'h10, 8'ha5);
      rd(5'h10, 8'hff, 8'ha5);
      wr(5'h13, 8'h40);
      frame(8'h03, 8'h3f, 16'h0000);
      rd(5'h14, 8'he0, 8'h00);
      rd(5'h16, 8'hff, 8'h03);
      rd(5'h14, 8'hc0, 8'h80);
      `CHK(rx_end_at_output_o, 1'b1)
      rd(5'h16, 8'hff, 8'h3f);
      rd(5'h14, 8'he0, 8'h20);
      rd(5'h18, 8'hff, fr[15:8]);
      rd(5'h19, 8'hff, fr[7:0]);
      frame(8'h03, 8'h3f, 16'h0001);
      rd(5'h14, 8'hc0, 8'h00);
      rd(5'h16, 8'hff, 8'h03);
      rd(5'h14, 8'hc0, 8'hc0);
      rd(5'h16, 8'hff, 8'h3f);
      wr(5'h13, 8'h60);
      wr(5'h16, 8'h03);
      wr(5'h13, 8'h70);
      wr(5'h16, 8'h3f);
      rd(5'h13, 8'h18, 8'h00);
      wait_rx_end_written_irq(3);
      rd(5'h16, 8'hff, 8'h03);
      rd(5'h14, 8'hc0, 8'h80);
      rd(5'h16, 8'hff, 8'h3f);
      wr(5'h16, 8'h55);
      repeat (400) @(negedge clk_sys_i);
      rd(5'h14, 8'h22, 8'h22);
      wr(5'h1b, 8'h01);
      // the soft reset cycle itself serves no access
      @(negedge clk_sys_i);
      rd(5'h13, 8'hff, 8'h00);
      wr(5'h13, 8'h24);
      for (k = 0; k < 300 && tx_data_o === 1'b1; k++) @(negedge clk_sys_i);
      `CHK(tx_data_o, 1'b0)
      wr(5'h13, 8'h2c);
      wr(5'h16, 8'haa);
      repeat (300) @(negedge clk_sys_i);
      rd(5'h14, 8'h03, 8'h01);
      `CHK(n_rx_end_written_irq, 3)
      summarize();
   end
endmodule
